//--- common/wake_link_if.sv
`timescale 1ns/1ps
interface wake_link_if
(
	input wire logic button
);
	logic sclk;
	logic sen;
	logic sdata;
	logic sdata_dev_o;
	logic sdata_dev_oe;
	logic sdata_host_o;
	logic sdata_host_oe;
	logic wake;
	logic wake_host_o;
	logic wake_host_oe;
	logic tx_data;
	logic host_clock_out;

	// Weak pull-down when nobody drives the data line
	assign sdata = sdata_dev_oe ? sdata_dev_o : (sdata_host_oe ? sdata_host_o : 1'b0);
	// A driving host pin overrides the button pull-up
	assign wake = wake_host_oe ? wake_host_o : button;

	modport device
	(
		input  sclk,
		input  sen,
		input  sdata,
		input  wake,
		input  tx_data,
		output sdata_dev_o,
		output sdata_dev_oe,
		output host_clock_out
	);

	modport host
	(
		output sclk,
		output sen,
		output sdata_host_o,
		output sdata_host_oe,
		output wake_host_o,
		output wake_host_oe,
		output tx_data,
		input  sdata,
		input  wake,
		input  host_clock_out
	);
endinterface

//--- common/wake_power_pkg.sv
package wake_power_pkg;
	localparam int          DIR_BIT      = 0;
	localparam int          SEL_LSB      = 1;
	localparam int          SEL_W        = 3;
	localparam int          CFG_W        = 24;
	localparam int          STAT_W       = 8;
	localparam logic [5:0]  INSTR_LEN    = 6'h08;
	localparam logic [5:0]  FRAME_MAX    = 6'h20;
	localparam logic [5:0]  STAT_FRAME   = 6'h10;
	localparam logic [2:0]  REG_CONFIG   = 3'h0;
	localparam logic [2:0]  REG_STATUS   = 3'h1;
	localparam logic [2:0]  REG_TEST     = 3'h5;
	localparam int          TAIL_LSB     = 11;
	localparam int          TAIL_W       = 4;
	localparam int          CLK_DIS_BIT  = 18;
	localparam logic [23:0] CONFIG_RESET = 24'h000380;
	localparam logic [23:0] TEST_RESET   = 24'h000000;
	localparam int          CLK_PERIOD_NS    = 4;
	localparam int          WAKE_TIMEOUT_NS  = 2000;
	localparam int          OSC_STARTUP_NS   = 4000;
	localparam logic [11:0] WTO_CYCLES   = 12'((WAKE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] OSC_CYCLES   = 12'((OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0]  HCLK_HALF    = 2'h1;
	localparam logic [3:0]  SER_HALF     = 4'h7;

	typedef enum logic [2:0]
	{
		PWR_OFF   = 3'h0,
		PWR_START = 3'h1,
		PWR_RUN   = 3'h2,
		PWR_TAIL  = 3'h3
	} pwr_state_t;

	typedef enum logic [2:0]
	{
		SER_IDLE  = 3'h0,
		SER_LEAD  = 3'h1,
		SER_HIGH  = 3'h2,
		SER_LOW   = 3'h3,
		SER_TRAIL = 3'h4
	} ser_state_t;

	// Total frame length in serial clocks for a register code
	function automatic logic [5:0] frame_len(input logic [2:0] sel);
		frame_len = (sel == REG_CONFIG || sel == REG_TEST) ? FRAME_MAX : STAT_FRAME;
	endfunction
endpackage

//--- hdl/wake_power_device.sv
`timescale 1ns/1ps
module wake_power_device
	import wake_power_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	wake_link_if.device            lnk,
	input  wire logic              rx_select,
	input  wire logic [STAT_W-1:0] status_in,
	output logic      [CFG_W-1:0]  config_value,
	output logic      [CFG_W-1:0]  test_value,
	output logic                   osc_on,
	output logic                   tx_rf_on,
	output logic                   rf_tx_data,
	output logic                   rx_active,
	output logic                   wake_held
);
	logic             sclk_m;
	logic             sclk_s;
	logic             sclk_p;
	logic             sen_m;
	logic             sen_s;
	logic             sen_p;
	logic             sdata_m;
	logic             sdata_s;
	logic             wake_m;
	logic             wake_s;
	logic             tx_m;
	logic             tx_s;
	logic             sclk_fall;
	logic             sclk_rise;
	logic             sen_fall;
	logic             sen_rise;
	logic [5:0]       bit_cnt;
	logic [7:0]       instr;
	logic [CFG_W-1:0] data_sr;
	logic [CFG_W-1:0] read_word;
	logic [4:0]       data_idx;
	logic             is_read;
	logic [2:0]       sel;
	logic [11:0]      wto_cnt;
	logic [11:0]      osc_cnt;
	logic [TAIL_W-1:0] tail_left;
	logic [1:0]       div_cnt;
	logic             hclk;
	logic             hclk_toggle;
	logic             clk_disabled;
	logic             keep_running;
	pwr_state_t       state;
	pwr_state_t       next_state;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{sclk_m, sclk_s, sclk_p} <= 3'h0;
			{sen_m, sen_s, sen_p} <= 3'h0;
			{sdata_m, sdata_s} <= 2'h0;
			{wake_m, wake_s} <= 2'h0;
			{tx_m, tx_s} <= 2'h0;
		end
		else
		begin
			sclk_m <= lnk.sclk;
			sclk_s <= sclk_m;
			sclk_p <= sclk_s;
			sen_m <= lnk.sen;
			sen_s <= sen_m;
			sen_p <= sen_s;
			sdata_m <= lnk.sdata;
			sdata_s <= sdata_m;
			wake_m <= lnk.wake;
			wake_s <= wake_m;
			tx_m <= lnk.tx_data;
			tx_s <= tx_m;
		end
	end

	assign sclk_fall = sclk_p & ~sclk_s;
	assign sclk_rise = ~sclk_p & sclk_s;
	assign sen_fall = sen_p & ~sen_s;
	assign sen_rise = ~sen_p & sen_s;
	assign is_read = instr[DIR_BIT];
	assign sel = instr[SEL_LSB +: SEL_W];
	assign data_idx = 5'(bit_cnt - INSTR_LEN);

	// Serial shift-in, least significant bit first
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bit_cnt <= 6'h00;
			instr <= 8'h00;
			data_sr <= 24'h000000;
		end
		else if (sen_rise)
		begin
			bit_cnt <= 6'h00;
			instr <= 8'h00;
			data_sr <= 24'h000000;
		end
		else if (sen_s && sclk_fall && bit_cnt < FRAME_MAX)
		begin
			bit_cnt <= bit_cnt + 6'h01;
			if (bit_cnt < INSTR_LEN)
				instr[bit_cnt[2:0]] <= sdata_s;
			else if (!is_read)
				data_sr[data_idx] <= sdata_s;
		end
	end

	// Only a complete write frame is committed, so a cut-off transfer never half-loads a register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			config_value <= CONFIG_RESET;
			test_value <= TEST_RESET;
		end
		else if (sen_fall && !is_read && bit_cnt == FRAME_MAX)
		begin
			case (sel)
				REG_CONFIG: config_value <= data_sr;
				REG_TEST: test_value <= data_sr;
				default: ;
			endcase
		end
	end

	always_comb
	begin
		case (sel)
			REG_CONFIG: read_word = config_value;
			REG_STATUS: read_word = {16'h0000, status_in};
			REG_TEST: read_word = test_value;
			default: read_word = 24'h000000;
		endcase
	end

	// Read data changes on the rising serial clock so it is stable at the host's falling edge
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lnk.sdata_dev_oe <= 1'b0;
			lnk.sdata_dev_o <= 1'b0;
		end
		else if (!sen_s)
		begin
			lnk.sdata_dev_oe <= 1'b0;
			lnk.sdata_dev_o <= 1'b0;
		end
		else if (sclk_rise && is_read && bit_cnt >= INSTR_LEN && bit_cnt < FRAME_MAX)
		begin
			lnk.sdata_dev_oe <= 1'b1;
			lnk.sdata_dev_o <= read_word[data_idx];
		end
	end

	// Deassertion of wake is stretched by the timeout so button scanning does not shut us down
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wake_held <= 1'b0;
			wto_cnt <= 12'h000;
		end
		else if (wake_s)
		begin
			wake_held <= 1'b1;
			wto_cnt <= WTO_CYCLES;
		end
		else if (wto_cnt != 12'h000)
		begin
			wto_cnt <= wto_cnt - 12'h001;
			if (wto_cnt == 12'h001)
				wake_held <= 1'b0;
		end
	end

	assign clk_disabled = rx_select & config_value[CLK_DIS_BIT];
	assign keep_running = wake_held | (rx_select & ~config_value[CLK_DIS_BIT]);

	always_comb
	begin
		next_state = state;
		case (state)
			PWR_OFF:
				if (wake_s || keep_running)
					next_state = PWR_START;
			PWR_START:
				if (osc_cnt == 12'h000)
					next_state = PWR_RUN;
			PWR_RUN:
				// A disabled clock is first let down to low so it never parks high in standby
				if (!keep_running && !(clk_disabled && hclk))
					next_state = clk_disabled ? PWR_OFF : PWR_TAIL;
			PWR_TAIL:
				if (keep_running)
					next_state = PWR_RUN;
				else if (tail_left == 4'h0 && !hclk)
					next_state = PWR_OFF;
			default:
				next_state = PWR_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= PWR_OFF;
		else
			state <= next_state;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			osc_cnt <= 12'h000;
		else if (state == PWR_OFF)
			osc_cnt <= OSC_CYCLES;
		else if (state == PWR_START && osc_cnt != 12'h000)
			osc_cnt <= osc_cnt - 12'h001;
	end

	// Host clock divider; the host never sees a runt pulse and it stops low after a nonzero tail, but with a zero tail length it can toggle high as PWR_TAIL is left
	assign hclk_toggle = (div_cnt == HCLK_HALF) &&
		(state == PWR_RUN || state == PWR_TAIL) && (!clk_disabled || hclk);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			div_cnt <= 2'h0;
			hclk <= 1'b0;
		end
		else if (hclk_toggle)
		begin
			div_cnt <= 2'h0;
			hclk <= ~hclk;
		end
		else if (state == PWR_RUN || state == PWR_TAIL)
			div_cnt <= div_cnt + 2'h1;
		else
			div_cnt <= 2'h0;
	end

	assign lnk.host_clock_out = hclk;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tail_left <= 4'h0;
		else if (state == PWR_RUN)
			tail_left <= config_value[TAIL_LSB +: TAIL_W];
		else if (state == PWR_TAIL && hclk_toggle && tail_left != 4'h0)
			tail_left <= tail_left - 4'h1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			osc_on <= 1'b0;
			tx_rf_on <= 1'b0;
			rf_tx_data <= 1'b0;
			rx_active <= 1'b0;
		end
		else
		begin
			osc_on <= (next_state != PWR_OFF);
			tx_rf_on <= (state == PWR_RUN) && !rx_select && wake_held;
			rf_tx_data <= (state == PWR_RUN) && !rx_select && wake_held && tx_s;
			rx_active <= (state == PWR_RUN) && rx_select && wake_held;
		end
	end
endmodule

//--- hdl/wake_power_host.sv
`timescale 1ns/1ps
module wake_power_host
	import wake_power_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	wake_link_if.host             lnk,
	input  wire logic             cmd_valid,
	input  wire logic             cmd_read,
	input  wire logic [2:0]       cmd_reg,
	input  wire logic [CFG_W-1:0] cmd_wdata,
	output logic                  cmd_ready,
	output logic                  rsp_valid,
	output logic      [CFG_W-1:0] rsp_rdata,
	input  wire logic             wake_high,
	input  wire logic             scan_low,
	input  wire logic             tx_bit,
	output logic                  wake_seen,
	output logic                  host_clock_seen
);
	logic        sdata_m;
	logic        sdata_s;
	logic        wake_m;
	logic        hclk_m;
	logic [31:0] frame;
	logic [5:0]  bit_idx;
	logic [5:0]  total;
	logic        rd;
	logic [3:0]  hc;
	logic        half_done;
	logic        host_drives;
	ser_state_t  state;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{sdata_m, sdata_s} <= 2'h0;
			{wake_m, wake_seen} <= 2'h0;
			{hclk_m, host_clock_seen} <= 2'h0;
		end
		else
		begin
			sdata_m <= lnk.sdata;
			sdata_s <= sdata_m;
			wake_m <= lnk.wake;
			wake_seen <= wake_m;
			hclk_m <= lnk.host_clock_out;
			host_clock_seen <= hclk_m;
		end
	end

	// Scan overrides a high request; releasing both returns the pin to an input
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lnk.wake_host_oe <= 1'b0;
			lnk.wake_host_o <= 1'b0;
			lnk.tx_data <= 1'b0;
		end
		else
		begin
			lnk.wake_host_oe <= wake_high | scan_low;
			lnk.wake_host_o <= wake_high & ~scan_low;
			lnk.tx_data <= tx_bit;
		end
	end

	assign cmd_ready = (state == SER_IDLE);
	assign half_done = (hc == SER_HALF);
	assign host_drives = (bit_idx < INSTR_LEN) || !rd;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hc <= 4'h0;
		else if (state == SER_IDLE || half_done)
			hc <= 4'h0;
		else
			hc <= hc + 4'h1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= SER_IDLE;
			frame <= 32'h00000000;
			bit_idx <= 6'h00;
			total <= 6'h00;
			rd <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 24'h000000;
			lnk.sen <= 1'b0;
			lnk.sclk <= 1'b0;
			lnk.sdata_host_o <= 1'b0;
			lnk.sdata_host_oe <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			case (state)
				SER_IDLE:
					if (cmd_valid)
					begin
						frame <= {cmd_wdata, 4'h0, cmd_reg, cmd_read};
						rd <= cmd_read;
						total <= frame_len(cmd_reg);
						bit_idx <= 6'h00;
						rsp_rdata <= 24'h000000;
						lnk.sen <= 1'b1;
						state <= SER_LEAD;
					end
				SER_LEAD, SER_LOW:
					if (half_done)
					begin
						lnk.sclk <= 1'b1;
						lnk.sdata_host_oe <= host_drives;
						lnk.sdata_host_o <= host_drives & frame[bit_idx[4:0]];
						state <= SER_HIGH;
					end
				SER_HIGH:
					if (half_done)
					begin
						lnk.sclk <= 1'b0;
						if (rd && bit_idx >= INSTR_LEN)
							rsp_rdata[5'(bit_idx - INSTR_LEN)] <= sdata_s;
						if (rd && bit_idx == INSTR_LEN - 6'h01)
							lnk.sdata_host_oe <= 1'b0;
						bit_idx <= bit_idx + 6'h01;
						state <= (bit_idx + 6'h01 == total) ? SER_TRAIL : SER_LOW;
					end
				SER_TRAIL:
					if (half_done)
					begin
						lnk.sen <= 1'b0;
						lnk.sdata_host_oe <= 1'b0;
						lnk.sdata_host_o <= 1'b0;
						rsp_valid <= 1'b1;
						state <= SER_IDLE;
					end
				default:
					state <= SER_IDLE;
			endcase
		end
	end
endmodule

//--- test/tb_transceiver_wake_power_control.sv
`timescale 1ns/1ps
module tb_transceiver_wake_power_control import wake_power_pkg::*;;
	logic        clk, reset_n, button, rx_select, cmd_valid, cmd_read, wake_high, scan_low, tx_bit;
	logic [2:0]  cmd_reg;
	logic [23:0] cmd_wdata, config_value, test_value, rsp_rdata, cfg, tst, d;
	logic [7:0]  status_in;
	logic        osc_on, tx_rf_on, rf_tx_data, rx_active, wake_held, cmd_ready, rsp_valid;
	logic        wake_seen, host_clock_seen;
	int          bad_count, total_checks, cycles, e, n;
	logic [23:0] exp_q[$];

	wake_link_if lnk (.button(button));
	wake_power_device u_wake_power_device (.clk(clk), .reset_n(reset_n), .lnk(lnk), .rx_select(rx_select),
		.status_in(status_in), .config_value(config_value), .test_value(test_value), .osc_on(osc_on),
		.tx_rf_on(tx_rf_on), .rf_tx_data(rf_tx_data), .rx_active(rx_active), .wake_held(wake_held));
	wake_power_host u_wake_power_host (.clk(clk), .reset_n(reset_n), .lnk(lnk), .cmd_valid(cmd_valid),
		.cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wake_high(wake_high), .scan_low(scan_low),
		.tx_bit(tx_bit), .wake_seen(wake_seen), .host_clock_seen(host_clock_seen));
	wake_link_assertions u_wake_link_assertions (.clk(clk), .reset_n(reset_n), .sclk(lnk.sclk), .sen(lnk.sen),
		.sdata_dev_oe(lnk.sdata_dev_oe), .sdata_host_oe(lnk.sdata_host_oe), .wake(lnk.wake),
		.host_clock_out(lnk.host_clock_out));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check_value(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Read data is compared by the response watcher, in issue order
	task automatic reg_op(input logic rd, input logic [2:0] sel, input logic [23:0] wd, input logic [23:0] ex);
		exp_q.push_back(ex);
		while (cmd_ready !== 1'b1)
			tick(1);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_reg = sel;
		cmd_wdata = wd;
		tick(1);
		cmd_valid = 1'b0;
		check_value("busy", 1'b0, cmd_ready);
		check_value("enable", 1'b1, lnk.sen);
		while (rsp_valid !== 1'b1)
			tick(1);
		tick(8);
	endtask

	// Host clock toggles every two cycles, so one look per cycle sees each edge
	task automatic count_edges(input int k, output int edges);
		logic p;
		edges = 0;
		p = lnk.host_clock_out;
		repeat (k)
		begin
			tick(1);
			if (lnk.host_clock_out !== p)
				edges++;
			p = lnk.host_clock_out;
		end
	endtask

	task automatic power_cycle(input logic by_button);
		tx_bit = 1'b1;
		if (by_button)
			button = 1'b1;
		else
			wake_high = 1'b1;
		tick(8);
		check_value("osc on", 1'b1, osc_on);
		count_edges(900, e);
		check_value("early clock", 24'h0, 24'(e));
		tick(200);
		check_value("wake seen", 1'b1, wake_seen);
		check_value("tx on", 1'b1, tx_rf_on);
		check_value("tx data", 1'b1, rf_tx_data);
		check_value("wake held", 1'b1, wake_held);
		tx_bit = 1'($urandom());
		tick(6);
		check_value("tx data follows", tx_bit, rf_tx_data);
		scan_low = by_button;
		tick(300);
		scan_low = 1'b0;
		tick(20);
		check_value("tx after scan", 1'b1, tx_rf_on);
		button = 1'b0;
		wake_high = 1'b0;
		n = 0;
		while (tx_rf_on === 1'b1 && n < 700)
		begin
			tick(1);
			n++;
		end
		check_value("timeout near", 1'b1, (n >= 495 && n <= 515));
		check_value("tx data off", 1'b0, rf_tx_data);
		check_value("wake released", 1'b0, wake_held);
		count_edges(100, e);
		check_value("tail edges", 1'b1, (e >= 4 && e <= 6));
		check_value("osc off", 1'b0, osc_on);
		check_value("host clock seen", 1'b0, host_clock_seen);
		$display("power cycle done, button %0d", by_button);
	endtask

	// Looked at mid-cycle so the one-cycle pulse is seen once, clear of the launching edge
	always @(negedge clk)
		if (rsp_valid === 1'b1)
			check_value("response data", exp_q.pop_front(), rsp_rdata);

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			bad_count++;
			$display("[FAIL] run length expected end seen hang");
			wrap_up();
		end
	end

	initial
	begin
		{reset_n, button, rx_select, cmd_valid, cmd_read, wake_high, scan_low, tx_bit} = 8'h00;
		cmd_reg = 3'h0;
		cmd_wdata = 24'h000000;
		void'($urandom(32'h6668CB50));
		status_in = 8'($urandom());
		tick(16);
		reset_n = 1'b1;
		tick(2);
		cfg = CONFIG_RESET;
		tst = TEST_RESET;
		check_value("config reset", cfg, config_value);
		for (int c = 0; c < 8; c++)
		begin
			d = 24'($urandom());
			if (c == 0)
				d = {d[23:19], 1'b0, d[17:15], 4'h5, d[10:0]};
			reg_op(1'b0, 3'(c), d, 24'h000000);
			if (c == 0)
				cfg = d;
			if (c == 5)
				tst = d;
			check_value("config", cfg, config_value);
			check_value("test", tst, test_value);
			reg_op(1'b1, 3'(c), 24'h000000, c == 0 ? cfg : c == 5 ? tst : c == 1 ? {16'h0000, status_in} : 24'h0);
		end
		$display("register tests done");
		power_cycle(1'b1);
		power_cycle(1'b0);
		rx_select = 1'b1;
		wake_high = 1'b1;
		tick(1100);
		check_value("rx active", 1'b1, rx_active);
		check_value("rx no tx", 1'b0, tx_rf_on);
		count_edges(20, e);
		check_value("rx clock", 24'hA, 24'(e));
		wake_high = 1'b0;
		tick(600);
		check_value("standby", 1'b0, rx_active);
		count_edges(20, e);
		check_value("standby clock", 24'hA, 24'(e));
		reg_op(1'b0, REG_CONFIG, cfg | 24'h040000, 24'h000000);
		tick(10);
		check_value("osc stopped", 1'b0, osc_on);
		wake_high = 1'b1;
		tick(1100);
		check_value("rx no clock", 1'b1, rx_active);
		count_edges(20, e);
		check_value("clock held off", 24'h0, 24'(e));
		$display("receiver tests done");
		wrap_up();
	end
endmodule

//--- test/wake_link_assertions.sv
`timescale 1ns/1ps
module wake_link_assertions
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic sen,
	input wire logic sdata_dev_oe,
	input wire logic sdata_host_oe,
	input wire logic wake,
	input wire logic host_clock_out
);
	logic [10:0] low_run;
	logic [10:0] wake_low;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Saturating run length of a quiet host clock
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			low_run <= 11'h000;
		else if (host_clock_out)
			low_run <= 11'h000;
		else if (low_run != 11'h7FF)
			low_run <= low_run + 11'h001;

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			wake_low <= 11'h000;
		else if (wake)
			wake_low <= 11'h000;
		else if (wake_low != 11'h7FF)
			wake_low <= wake_low + 11'h001;

	chk_line_shared: assert property (!(sdata_dev_oe && sdata_host_oe))
		else $error("data line driven by both ends");
	chk_oe_in_frame: assert property ($rose(sdata_dev_oe) |-> sen)
		else $error("device drives data outside a frame");
	chk_oe_release: assert property ($fell(sen) |-> ##[0:6] !sdata_dev_oe)
		else $error("device keeps data line after enable fall");
	chk_sclk_framed: assert property (sclk |-> sen)
		else $error("serial clock high without enable");
	chk_sclk_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("serial clock high phase wrong");
	chk_sen_lead: assert property ($rose(sen) |-> !sclk [*3])
		else $error("serial clock too soon after enable");
	chk_osc_startup: assert property ($rose(host_clock_out) |-> (low_run <= 11'h003 || low_run >= 11'h3E8))
		else $error("host clock restarted before oscillator startup");
	chk_wake_hold: assert property (($fell(host_clock_out) && wake_low < 11'h1D6) |-> ##2 host_clock_out)
		else $error("host clock stopped inside wake timeout");
endmodule
